//--- verilog/port_tx_lockup_monitor.sv
// The AXI4-Lite interface to the registers was decided locally.
`timescale 1ns/1ps
`default_nettype none
module port_tx_lockup_monitor #(
    parameter int NUM_PORTS = 5,
    parameter int VLAN_ENTRIES = 4,
    parameter logic [10:0] TXQ_LIMIT = 11'h600
) (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [15:0] s_axi_awaddr,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    output logic [1:0] s_axi_bresp,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [15:0] s_axi_araddr,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic ingress_valid,
    input wire logic [$clog2(NUM_PORTS)-1:0] ingress_src_port,
    input wire logic [$clog2(NUM_PORTS)-1:0] ingress_dst_port,
    input wire logic [NUM_PORTS-1:0] port_tx_done,
    input wire logic [NUM_PORTS-1:0] port_pause_sent,
    input wire logic [NUM_PORTS-1:0] port_fault_event,
    input wire logic [NUM_PORTS-1:0] port_half_duplex,
    input wire logic [NUM_PORTS-1:0] port_gigabit
);
    localparam int PW = $clog2(NUM_PORTS);

    logic aw_held_reg, w_held_reg;
    logic [13:0] aw_idx_reg;
    logic [31:0] w_data_reg;
    logic [3:0] w_strb_reg;
    logic wr_fire;
    logic [7:0] lookup_ctrl_reg;
    logic soft_reset_reg;
    logic vlan_en;
    logic [10:0] free_reg;
    logic [10:0] txq_reg [NUM_PORTS];
    logic [NUM_PORTS-1:0] locked_reg;
    logic [31:0] rx_drop_reg [NUM_PORTS];
    logic [31:0] tx_drop_reg [NUM_PORTS];
    logic [31:0] unicast_reg [NUM_PORTS];
    logic [7:0] tag_hi_reg [NUM_PORTS];
    logic [7:0] tag_lo_reg [NUM_PORTS];
    logic [31:0] vlan_reg [VLAN_ENTRIES];
    logic [NUM_PORTS-1:0] enq, deq, tx_drop_evt, rx_drop_evt;
    logic mem_empty;
    logic [10:0] deq_total;
    logic [31:0] rd_data;
    logic rd_ok, wr_ok;
    logic [13:0] ar_idx;

    assign vlan_en = lookup_ctrl_reg[lockup_pkg::VLAN_EN_BIT];
    assign mem_empty = (free_reg == 11'h000);
    assign ar_idx = s_axi_araddr[15:2];
    // Write performs once both halves are held and no response is pending
    assign wr_fire = aw_held_reg && w_held_reg && !s_axi_bvalid;

    // Write address and data are taken independently, in either order
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_held_reg <= 1'b0;
            aw_idx_reg <= 14'h0000;
        end else if (s_axi_awvalid && s_axi_awready) begin
            aw_held_reg <= 1'b1;
            aw_idx_reg <= s_axi_awaddr[15:2];
        end else if (wr_fire) begin
            aw_held_reg <= 1'b0;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            w_held_reg <= 1'b0;
            w_data_reg <= 32'h0000_0000;
            w_strb_reg <= 4'h0;
        end else if (s_axi_wvalid && s_axi_wready) begin
            w_held_reg <= 1'b1;
            w_data_reg <= s_axi_wdata;
            w_strb_reg <= s_axi_wstrb;
        end else if (wr_fire) begin
            w_held_reg <= 1'b0;
        end
    end

    // Ready drops while a half is held, so nothing is ever overwritten
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_awready <= 1'b0;
            s_axi_wready <= 1'b0;
        end else begin
            s_axi_awready <= !aw_held_reg && !(s_axi_awvalid && s_axi_awready)
                && !wr_fire;
            s_axi_wready <= !w_held_reg && !(s_axi_wvalid && s_axi_wready)
                && !wr_fire;
        end
    end

    // Write decode: read-only words answer OKAY, holes answer SLVERR
    always_comb begin
        wr_ok = 1'b0;
        if (aw_idx_reg == lockup_pkg::IDX_GLOBAL_RESET ||
            aw_idx_reg == lockup_pkg::IDX_LOOKUP_CTRL ||
            aw_idx_reg == lockup_pkg::IDX_FREE_STATUS)
            wr_ok = 1'b1;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (aw_idx_reg == lockup_pkg::IDX_QUEUE_BASE + 14'(p) ||
                aw_idx_reg == lockup_pkg::IDX_TAG_HI_BASE + 14'(p) ||
                aw_idx_reg == lockup_pkg::IDX_TAG_LO_BASE + 14'(p) ||
                aw_idx_reg == lockup_pkg::IDX_RX_DROP_BASE + 14'(p) ||
                aw_idx_reg == lockup_pkg::IDX_TX_DROP_BASE + 14'(p) ||
                aw_idx_reg == lockup_pkg::IDX_UNICAST_BASE + 14'(p))
                wr_ok = 1'b1;
        end
        for (int v = 0; v < VLAN_ENTRIES; v++) begin
            if (aw_idx_reg == lockup_pkg::IDX_VLAN_BASE + 14'(v))
                wr_ok = 1'b1;
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= lockup_pkg::RESP_OKAY;
        end else if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_ok ? lockup_pkg::RESP_OKAY
                                 : lockup_pkg::RESP_SLVERR;
        end else if (s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end

    // Control registers survive the soft reset on purpose
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lookup_ctrl_reg <= lockup_pkg::LOOKUP_CTRL_RESET;
            soft_reset_reg <= 1'b0;
        end else if (wr_fire && w_strb_reg[0]) begin
            if (aw_idx_reg == lockup_pkg::IDX_LOOKUP_CTRL)
                lookup_ctrl_reg <= w_data_reg[7:0];
            if (aw_idx_reg == lockup_pkg::IDX_GLOBAL_RESET)
                soft_reset_reg <= w_data_reg[lockup_pkg::SOFT_RESET_BIT];
        end
    end

    // VLAN table, wiped while the soft reset bit is set
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset_reg) begin
            for (int v = 0; v < VLAN_ENTRIES; v++)
                vlan_reg[v] <= lockup_pkg::COUNTER_RESET;
        end else if (wr_fire) begin
            for (int v = 0; v < VLAN_ENTRIES; v++) begin
                if (aw_idx_reg == lockup_pkg::IDX_VLAN_BASE + 14'(v)) begin
                    for (int b = 0; b < 4; b++)
                        if (w_strb_reg[b])
                            vlan_reg[v][8*b +: 8] <= w_data_reg[8*b +: 8];
                end
            end
        end
    end

    // Count drained blocks of all ports for the shared pool
    always_comb begin
        deq_total = 11'h000;
        for (int p = 0; p < NUM_PORTS; p++)
            deq_total = deq_total + 11'(deq[p]);
    end

    // Shared pool; one ingress frame per cycle takes one block
    always_ff @(posedge aclk) begin
        if (!aresetn || soft_reset_reg)
            free_reg <= lockup_pkg::FREE_IDLE;
        else
            free_reg <= free_reg - 11'(|enq) + deq_total;
    end

    // Declared before the per-port checks so every assertion sees them
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    genvar gp;
    generate
        for (gp = 0; gp < NUM_PORTS; gp++) begin : g_port
            // Frame events; pool empty halts all forwarding
            assign rx_drop_evt[gp] = ingress_valid && !soft_reset_reg &&
                ingress_src_port == PW'(gp) && mem_empty;
            assign tx_drop_evt[gp] = ingress_valid && !soft_reset_reg &&
                ingress_dst_port == PW'(gp) && !mem_empty &&
                txq_reg[gp] == TXQ_LIMIT;
            assign enq[gp] = ingress_valid && !soft_reset_reg &&
                ingress_dst_port == PW'(gp) && !mem_empty &&
                txq_reg[gp] != TXQ_LIMIT;
            // A locked port never drains; its queue can still fill but not empty
            assign deq[gp] = port_tx_done[gp] && !locked_reg[gp] &&
                !soft_reset_reg && txq_reg[gp] != 11'h000;

            always_ff @(posedge aclk) begin
                if (!aresetn || soft_reset_reg)
                    txq_reg[gp] <= lockup_pkg::TXQ_IDLE;
                else
                    txq_reg[gp] <= txq_reg[gp] + 11'(enq[gp])
                        - 11'(deq[gp]);
            end

            // Lock is sticky; only a reset clears it, and nothing reports it
            always_ff @(posedge aclk) begin
                if (!aresetn || soft_reset_reg)
                    locked_reg[gp] <= 1'b0;
                else if (port_fault_event[gp] && port_half_duplex[gp] &&
                         !port_gigabit[gp] && vlan_en)
                    locked_reg[gp] <= 1'b1;
            end

            // Counters are kept across the soft reset
            always_ff @(posedge aclk) begin
                if (!aresetn) begin
                    rx_drop_reg[gp] <= lockup_pkg::COUNTER_RESET;
                    tx_drop_reg[gp] <= lockup_pkg::COUNTER_RESET;
                    unicast_reg[gp] <= lockup_pkg::COUNTER_RESET;
                end else begin
                    rx_drop_reg[gp] <= rx_drop_reg[gp]
                        + 32'(rx_drop_evt[gp]);
                    tx_drop_reg[gp] <= tx_drop_reg[gp]
                        + 32'(tx_drop_evt[gp]);
                    unicast_reg[gp] <= unicast_reg[gp] + 32'(deq[gp])
                        + 32'(port_pause_sent[gp]);
                end
            end

            // Default tag bytes, wiped by the soft reset
            always_ff @(posedge aclk) begin
                if (!aresetn || soft_reset_reg) begin
                    tag_hi_reg[gp] <= 8'h00;
                    tag_lo_reg[gp] <= 8'h00;
                end else if (wr_fire && w_strb_reg[0]) begin
                    if (aw_idx_reg == lockup_pkg::IDX_TAG_HI_BASE + 14'(gp))
                        tag_hi_reg[gp] <= w_data_reg[7:0];
                    if (aw_idx_reg == lockup_pkg::IDX_TAG_LO_BASE + 14'(gp))
                        tag_lo_reg[gp] <= w_data_reg[7:0];
                end
            end

            a_lock_sticky: assert property (locked_reg[gp] && !soft_reset_reg
                |=> locked_reg[gp]) else $error("lock cleared itself");
            a_lock_cause: assert property ($rose(locked_reg[gp]) |->
                $past(vlan_en && port_half_duplex[gp] && !port_gigabit[gp]))
                else $error("lock without cause");
            a_locked_frozen: assert property (locked_reg[gp] &&
                !soft_reset_reg && !enq[gp] |=> $stable(txq_reg[gp]))
                else $error("locked queue moved");
            a_pause_counts: assert property (locked_reg[gp] &&
                port_pause_sent[gp] |=>
                unicast_reg[gp] == $past(unicast_reg[gp]) + 32'h0000_0001)
                else $error("pause not counted");
            a_memfull_rxdrop: assert property (ingress_valid && mem_empty &&
                !soft_reset_reg && ingress_src_port == PW'(gp) |=>
                rx_drop_reg[gp] == $past(rx_drop_reg[gp]) + 32'h0000_0001 &&
                tx_drop_reg[gp] == $past(tx_drop_reg[gp]))
                else $error("memory full drop wrong");
            a_qfull_txdrop: assert property (tx_drop_evt[gp] |=>
                tx_drop_reg[gp] == $past(tx_drop_reg[gp]) + 32'h0000_0001 &&
                txq_reg[gp] == TXQ_LIMIT - 11'($past(deq[gp])))
                else $error("queue full drop wrong");
        end
    endgenerate

    // Read decode, answered one cycle after the address is taken
    always_comb begin
        rd_data = 32'h0000_0000;
        rd_ok = 1'b1;
        if (ar_idx == lockup_pkg::IDX_GLOBAL_RESET)
            rd_data[lockup_pkg::SOFT_RESET_BIT] = soft_reset_reg;
        else if (ar_idx == lockup_pkg::IDX_LOOKUP_CTRL)
            rd_data[7:0] = lookup_ctrl_reg;
        else if (ar_idx == lockup_pkg::IDX_FREE_STATUS)
            rd_data[lockup_pkg::FREE_MSB:lockup_pkg::FREE_LSB] = free_reg;
        else
            rd_ok = 1'b0;
        for (int p = 0; p < NUM_PORTS; p++) begin
            if (ar_idx == lockup_pkg::IDX_QUEUE_BASE + 14'(p)) begin
                rd_data[lockup_pkg::BLK_W-1:0] = txq_reg[p];
                rd_ok = 1'b1;
            end
            if (ar_idx == lockup_pkg::IDX_TAG_HI_BASE + 14'(p)) begin
                rd_data[7:0] = tag_hi_reg[p];
                rd_ok = 1'b1;
            end
            if (ar_idx == lockup_pkg::IDX_TAG_LO_BASE + 14'(p)) begin
                rd_data[7:0] = tag_lo_reg[p];
                rd_ok = 1'b1;
            end
            if (ar_idx == lockup_pkg::IDX_RX_DROP_BASE + 14'(p)) begin
                rd_data = rx_drop_reg[p];
                rd_ok = 1'b1;
            end
            if (ar_idx == lockup_pkg::IDX_TX_DROP_BASE + 14'(p)) begin
                rd_data = tx_drop_reg[p];
                rd_ok = 1'b1;
            end
            if (ar_idx == lockup_pkg::IDX_UNICAST_BASE + 14'(p)) begin
                rd_data = unicast_reg[p];
                rd_ok = 1'b1;
            end
        end
        for (int v = 0; v < VLAN_ENTRIES; v++) begin
            if (ar_idx == lockup_pkg::IDX_VLAN_BASE + 14'(v)) begin
                rd_data = vlan_reg[v];
                rd_ok = 1'b1;
            end
        end
    end

    // One read in flight; arready held low until the data is taken
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0000_0000;
            s_axi_rresp <= lockup_pkg::RESP_OKAY;
        end else if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_data;
            s_axi_rresp <= rd_ok ? lockup_pkg::RESP_OKAY
                                 : lockup_pkg::RESP_SLVERR;
        end else if (s_axi_rvalid) begin
            if (s_axi_rready) begin
                s_axi_rvalid <= 1'b0;
                s_axi_arready <= 1'b1;
            end
        end else begin
            s_axi_arready <= 1'b1;
        end
    end

    // Checking helpers and assertions
    logic [11:0] blocks_total;
    always_comb begin
        blocks_total = {1'b0, free_reg};
        for (int p = 0; p < NUM_PORTS; p++)
            blocks_total = blocks_total + {1'b0, txq_reg[p]};
    end

    sequence s_wr_both;
        aw_held_reg && w_held_reg && !s_axi_bvalid;
    endsequence
    sequence s_soft_pulse;
        soft_reset_reg ##1 1'b1;
    endsequence

    a_blocks_conserved: assert property (blocks_total ==
        {1'b0, lockup_pkg::FREE_IDLE}) else $error("blocks lost");
    a_idle_after_soft: assert property (s_soft_pulse |-> free_reg ==
        lockup_pkg::FREE_IDLE && locked_reg == '0)
        else $error("soft reset left state");
    a_bresp_timing: assert property (s_wr_both |=> s_axi_bvalid)
        else $error("write response late");
    a_rx_drop_forward: assert property (ingress_valid && mem_empty
        |=> $stable(free_reg) || free_reg != 11'h000 ||
        $past(deq_total) != 11'h000) else $error("forwarded");
    a_read_one_cycle: assert property (s_axi_arvalid && s_axi_arready
        |=> s_axi_rvalid && !s_axi_arready)
        else $error("read answer late");
endmodule
`default_nettype wire

//--- verilog/lockup_pkg.sv
package lockup_pkg;
    // Register indices; byte address is four times the index
    localparam logic [13:0] IDX_GLOBAL_RESET = 14'h0003;
    localparam logic [13:0] IDX_LOOKUP_CTRL = 14'h0310;
    localparam logic [13:0] IDX_FREE_STATUS = 14'h03ac;
    localparam logic [13:0] IDX_QUEUE_BASE = 14'h0400;
    localparam logic [13:0] IDX_TAG_HI_BASE = 14'h0500;
    localparam logic [13:0] IDX_TAG_LO_BASE = 14'h0600;
    localparam logic [13:0] IDX_RX_DROP_BASE = 14'h0700;
    localparam logic [13:0] IDX_TX_DROP_BASE = 14'h0780;
    localparam logic [13:0] IDX_UNICAST_BASE = 14'h0800;
    localparam logic [13:0] IDX_VLAN_BASE = 14'h0900;
    // Field layout
    localparam int FREE_LSB = 16;
    localparam int FREE_MSB = 26;
    localparam int BLK_W = 11;
    localparam int VLAN_EN_BIT = 7;
    localparam int SOFT_RESET_BIT = 0;
    // Reset and idle values
    localparam logic [10:0] FREE_IDLE = 11'h7e8;
    localparam logic [10:0] TXQ_IDLE = 11'h000;
    localparam logic [7:0] LOOKUP_CTRL_RESET = 8'h00;
    localparam logic [31:0] COUNTER_RESET = 32'h0000_0000;
    // Normal operating limits seen by monitoring software
    localparam logic [10:0] NORMAL_FREE_MIN = 11'h580;
    localparam logic [10:0] NORMAL_TXQ_MAX = 11'h200;
    // AXI responses
    localparam logic [1:0] RESP_OKAY = 2'b00;
    localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

//--- verification/link_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
// Far-end station on each port, finishing frames the switch sends it
module link_partner_model (
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic [4:0] accept,
    input wire logic slow,
    output logic [4:0] port_tx_done
);
    logic [1:0] pace_reg;
    // Slow mode finishes a frame only every fourth cycle, so queues
    // really build up instead of draining at once
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pace_reg <= 2'h0;
            port_tx_done <= 5'h00;
        end else begin
            pace_reg <= pace_reg + 2'h1;
            port_tx_done <= (!slow || pace_reg == 2'h0) ? accept : 5'h00;
        end
    end
endmodule
`default_nettype wire

//--- verification/port_tx_lockup_monitor_tb.sv
`timescale 1ns/1ps
`default_nettype none
module port_tx_lockup_monitor_tb;
    typedef struct {
        logic [13:0] idx;
        logic [31:0] d;
        logic [31:0] m;
        logic [1:0] r;
    } note_t;
    logic aclk, aresetn, slow, ingress_valid;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    logic s_axi_rvalid, s_axi_rready;
    logic [15:0] s_axi_awaddr, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata, rd_last;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [2:0] ingress_src_port, ingress_dst_port;
    logic [4:0] port_tx_done, port_pause_sent, port_fault_event, accept;
    logic [4:0] port_half_duplex, port_gigabit;
    logic [7:0] ctrl_val;
    integer seed;
    int fail_count, check_count, exp_q[5], exp_rx[5], exp_tx[5], exp_uni[5];
    note_t rq[$], bq[$];

    port_tx_lockup_monitor uut (
        .aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
        .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr,
        .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
        .s_axi_rvalid, .s_axi_rready, .ingress_valid, .ingress_src_port,
        .ingress_dst_port, .port_tx_done, .port_pause_sent,
        .port_fault_event, .port_half_duplex, .port_gigabit
    );
    link_partner_model partner (.aclk, .aresetn, .accept, .slow,
        .port_tx_done);

    initial begin
        aclk = 1'b0;
        forever #2.5 aclk = ~aclk;
    end

    task automatic end_sim();
        $display("checks %0d mismatches %0d", check_count, fail_count);
        if (fail_count == 0 && check_count > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask
    task automatic give_up(input string what);
        $display("unexpected %s expected answer seen timeout", what);
        fail_count++;
        end_sim();
    endtask
    task automatic cmp_read(input note_t n, input logic [31:0] v,
            input logic [1:0] r);
        check_count++;
        if ((v & n.m) !== (n.d & n.m) || r !== n.r) begin
            $display("unexpected read %h expected %h/%b seen %h/%b",
                n.idx, n.d, n.r, v, r);
            fail_count++;
        end
    endtask
    task automatic cmp_resp(input note_t n, input logic [1:0] r);
        check_count++;
        if (r !== n.r) begin
            $display("unexpected bresp %h expected %b seen %b", n.idx, n.r, r);
            fail_count++;
        end
    endtask

    // Answers are matched to the oldest note at the handshake edge
    always @(posedge aclk) begin
        if (s_axi_rvalid && s_axi_rready) begin
            if (rq.size() == 0) give_up("read note");
            else cmp_read(rq.pop_front(), s_axi_rdata, s_axi_rresp);
        end
        if (s_axi_bvalid && s_axi_bready) begin
            if (bq.size() == 0) give_up("write note");
            else cmp_resp(bq.pop_front(), s_axi_bresp);
        end
    end

    task automatic wr(input logic [13:0] idx, input logic [31:0] d,
            input logic [1:0] r = lockup_pkg::RESP_OKAY);
        bit done;
        done = 1'b0;
        bq.push_back('{idx, 32'h0, 32'h0, r});
        @(posedge aclk);
        s_axi_awaddr <= {idx, 2'b00};
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 1'b0;
            if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 1'b0;
            done = s_axi_bvalid && s_axi_bready;
        end
        s_axi_bready <= 1'b0;
        if (!done) give_up("write");
    endtask
    task automatic rd(input logic [13:0] idx, input logic [31:0] d,
            input logic [31:0] m = 32'hffff_ffff,
            input logic [1:0] r = lockup_pkg::RESP_OKAY);
        bit done;
        done = 1'b0;
        rq.push_back('{idx, d, m, r});
        @(posedge aclk);
        s_axi_araddr <= {idx, 2'b00};
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        for (int i = 0; i < 50 && !done; i++) begin
            @(posedge aclk);
            if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 1'b0;
            done = s_axi_rvalid && s_axi_rready;
        end
        rd_last = s_axi_rdata;
        s_axi_rready <= 1'b0;
        if (!done) give_up("read");
    endtask
    // Back-to-back frames, one a cycle; drops are booked on the source
    task automatic send(input logic [2:0] dst, input int n, input bit drop);
        logic [2:0] src;
        for (int i = 0; i < n; i++) begin
            src = 3'(($random(seed) & 32'h7fff_ffff) % 5);
            if (drop) exp_rx[src]++;
            @(posedge aclk);
            ingress_valid <= 1'b1;
            ingress_src_port <= src;
            ingress_dst_port <= dst;
        end
        @(posedge aclk);
        ingress_valid <= 1'b0;
    endtask
    task automatic poll_zero(input int p);
        bit idle;
        idle = 1'b0;
        for (int i = 0; i < 100 && !idle; i++) begin
            rd(lockup_pkg::IDX_QUEUE_BASE + 14'(p), 32'h0, 32'h0);
            idle = (rd_last === 32'h0);
        end
        if (!idle) give_up("queue drain");
    endtask
    task automatic chk_all(input logic [10:0] f);
        rd(lockup_pkg::IDX_FREE_STATUS, {5'h00, f, 16'h0000});
        for (int p = 0; p < 5; p++) begin
            rd(lockup_pkg::IDX_QUEUE_BASE + 14'(p), 32'(exp_q[p]));
            rd(lockup_pkg::IDX_RX_DROP_BASE + 14'(p), 32'(exp_rx[p]));
            rd(lockup_pkg::IDX_TX_DROP_BASE + 14'(p), 32'(exp_tx[p]));
            rd(lockup_pkg::IDX_UNICAST_BASE + 14'(p), 32'(exp_uni[p]));
        end
    endtask
    task automatic pulse_fault(input logic [4:0] v);
        @(posedge aclk);
        port_fault_event <= v;
        @(posedge aclk);
        port_fault_event <= 5'h00;
    endtask

    // Main sequence; ports 0-2 half duplex, port 2 also gigabit
    initial begin
        seed = 32'heda6;
        {aresetn, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = 4'h0;
        {s_axi_arvalid, s_axi_rready, ingress_valid} = 3'h0;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 64'h0;
        s_axi_wstrb = 4'hf;
        {ingress_src_port, ingress_dst_port} = 6'h00;
        {port_pause_sent, port_fault_event} = 10'h000;
        port_half_duplex = 5'b00111;
        port_gigabit = 5'b00100;
        accept = 5'h1f;
        slow = 1'b1;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        chk_all(lockup_pkg::FREE_IDLE);
        rd(lockup_pkg::IDX_LOOKUP_CTRL, 32'h0);
        rd(14'h3fff, 32'h0, 32'hffff_ffff, lockup_pkg::RESP_SLVERR);
        wr(14'h3fff, 32'hffff_ffff, lockup_pkg::RESP_SLVERR);
        wr(lockup_pkg::IDX_FREE_STATUS, 32'h0);
        rd(lockup_pkg::IDX_FREE_STATUS, 32'h07e8_0000);
        $display("test reset and map done");
        // Half-duplex fault with VLAN off must not stop the port
        pulse_fault(5'b00010);
        send(3'd1, 3, 1'b0);
        poll_zero(1);
        exp_uni[1] += 3;
        chk_all(lockup_pkg::FREE_IDLE);
        $display("test vlan off done");
        ctrl_val = 8'($random(seed)) | 8'h80;
        wr(lockup_pkg::IDX_LOOKUP_CTRL, {24'h0, ctrl_val});
        rd(lockup_pkg::IDX_LOOKUP_CTRL, {24'h0, ctrl_val});
        slow <= 1'($random(seed));
        pulse_fault(5'b01110);
        send(3'd2, 1, 1'b0);
        send(3'd3, 1, 1'b0);
        send(3'd1, 2, 1'b0);
        send(3'd0, 1, 1'b0);
        poll_zero(2);
        poll_zero(3);
        poll_zero(0);
        @(posedge aclk);
        port_pause_sent <= 5'b00010;
        repeat (2) @(posedge aclk);
        port_pause_sent <= 5'h00;
        repeat (50) @(posedge aclk);
        exp_uni[0]++;
        exp_uni[2]++;
        exp_uni[3]++;
        exp_uni[1] += 2;
        exp_q[1] = 2;
        chk_all(11'h7e6);
        $display("test lockup done");
        send(3'd1, 32'h5ff, 1'b0);
        exp_q[1] = 32'h600;
        exp_tx[1] = 1;
        chk_all(11'h1e8);
        repeat (20) @(posedge aclk);
        chk_all(11'h1e8);
        accept <= 5'b11011;
        send(3'd2, 32'h1e8, 1'b0);
        exp_q[2] = 32'h1e8;
        send(3'd0, 4, 1'b1);
        chk_all(11'h000);
        $display("test exhaustion done");
        wr(lockup_pkg::IDX_TAG_HI_BASE, 32'h0000_005a);
        rd(lockup_pkg::IDX_TAG_HI_BASE, 32'h0000_005a);
        wr(lockup_pkg::IDX_VLAN_BASE, 32'h1234_5678);
        rd(lockup_pkg::IDX_VLAN_BASE, 32'h1234_5678);
        wr(lockup_pkg::IDX_GLOBAL_RESET, 32'h0000_0001);
        wr(lockup_pkg::IDX_GLOBAL_RESET, 32'h0000_0000);
        accept <= 5'h1f;
        exp_q = '{default: 0};
        chk_all(lockup_pkg::FREE_IDLE);
        rd(lockup_pkg::IDX_LOOKUP_CTRL, {24'h0, ctrl_val});
        rd(lockup_pkg::IDX_TAG_HI_BASE, 32'h0);
        rd(lockup_pkg::IDX_VLAN_BASE, 32'h0);
        wr(lockup_pkg::IDX_TAG_HI_BASE, 32'h0000_005a);
        send(3'd1, 1, 1'b0);
        poll_zero(1);
        exp_uni[1]++;
        chk_all(lockup_pkg::FREE_IDLE);
        $display("test soft reset done");
        // Pin reset in mid-run clears counters and control too
        @(posedge aclk);
        aresetn <= 1'b0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        exp_rx = '{default: 0};
        exp_tx = '{default: 0};
        exp_uni = '{default: 0};
        chk_all(lockup_pkg::FREE_IDLE);
        rd(lockup_pkg::IDX_LOOKUP_CTRL, 32'h0);
        $display("test pin reset done");
        end_sim();
    end
endmodule
`default_nettype wire
